//--- sra_shift.sv
// SDRAM row/column address shifter with AHB-Lite configuration registers
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Row and column addresses share the external address pins, shifted per phase.
// - Legacy shift pattern follows only the legacy width select.
// - Legacy latches pins 14..11 (x8) or 15..10 (x16) at row time.
// - Legacy precharge pin is driven low on every read and write.
// - Legacy x16: row bits 23..10; column keeps 23..21,19..18, A10 low, 9..2.
// - Newer shift follows column size and bus width; row and bank sizes pick bank bits.
// - Newer bank bits latched at row time, at pin 13/14/15, one or two wide.
// - Newer variant drives pin 12 (SDRAM A10) low in column cycles for column size codes 00 to 10.
// - Newer row puts bit columns+s on pin 2; column puts bit s there.
// - Newer variant: narrower buses present lower-order byte address bits on the pins.
// - Latched bits captured at activate and reused for column commands to that bank.
module sra_shift
	import sra_pkg::*;
(
	input  wire logic              hclk,        // Bus and memory clock
	input  wire logic              hresetn,     // Asynchronous reset, active low
	input  wire logic              hsel,        // Slave select
	input  wire logic [31:0]       haddr,       // Byte address
	input  wire logic [1:0]        htrans,      // Transfer type
	input  wire logic              hwrite,      // Write when high
	input  wire logic [2:0]        hsize,       // Transfer size
	input  wire logic [31:0]       hwdata,      // Write data
	input  wire logic              hready,      // Bus ready in
	output logic      [31:0]       hrdata,      // Read data
	output logic                   hreadyout,   // Slave ready
	output logic                   hresp,       // Always OKAY
	input  wire sra_cmd_t          cmd,         // Command from the sequencer
	output logic      [EA_W-1:0]   ext_addr_pins,      // Pins 21..2
	output logic                   precharge_addr_pin, // Legacy A10 pin
	output logic                   addr_valid,  // Pins updated this cycle
	output sra_cmd_kind_t          addr_kind    // Command the pins belong to
);

	////////////////////////////////////////////////////////////////////////////
	// Mapping functions

	function automatic int col_bits(input sra_cfg_t c);
		return NEW_COL_BASE + int'(c.column_size_field);
	endfunction

	function automatic int bank_pin(input sra_cfg_t c);
		unique case (c.row_size_field)
			2'b00:   return BANK_PIN_R00;
			2'b01:   return BANK_PIN_R01;
			default: return BANK_PIN_R11;
		endcase
	endfunction

	// Pins holding bank select bits in the newer variant
	function automatic logic [EA_W-1:0] bank_mask(input sra_cfg_t c);
		logic [EA_W-1:0] m;
		int              b;
		m = '0;
		b = bank_pin(c) - EA_LO;
		m[b] = 1'b1;
		if (c.bank_size_field)
			m[b+1] = 1'b1;
		return m;
	endfunction

	// Pins latched at row time in the legacy variant
	function automatic logic [EA_W-1:0] legacy_mask(input sra_cfg_t c);
		logic [EA_W-1:0] m;
		int              lo;
		int              hi;
		m  = '0;
		lo = c.legacy_width_select ? LEG_LAT_X16_LO : LEG_LAT_X8_LO;
		hi = c.legacy_width_select ? LEG_TOP_X16 : LEG_TOP_X8;
		for (int p = EA_LO; p <= EA_HI; p++) begin
			if (p >= lo && p <= hi && p != LEG_GAP_PIN)
				m[p-EA_LO] = 1'b1;
		end
		return m;
	endfunction

	function automatic sra_pins_t ras_map(input logic [ADDR_W-1:0] a, input sra_cfg_t c);
		sra_pins_t r;
		int        base;
		int        top;
		r = '0;
		if (c.newer_variant) begin
			base = col_bits(c) + int'(c.bus_width);
			for (int p = EA_LO; p <= NEW_ROW_TOP; p++)
				r.ea[p-EA_LO] = a[base+p-EA_LO];
		end else begin
			base = c.legacy_width_select ? LEG_RAS_X16 : LEG_RAS_X8;
			top  = c.legacy_width_select ? LEG_TOP_X16 : LEG_TOP_X8;
			for (int p = EA_LO; p <= LEG_LOW_TOP; p++)
				r.ea[p-EA_LO] = a[base+p-EA_LO];
			r.precharge_addr_pin = a[base+LEG_LOW_TOP-EA_LO+1];
			for (int p = LEG_GAP_PIN + 1; p <= top; p++)
				r.ea[p-EA_LO] = a[base+p-EA_LO];
		end
		return r;
	endfunction

	function automatic sra_pins_t cas_map(input logic [ADDR_W-1:0] a, input sra_cfg_t c,
	                                      input logic [EA_W-1:0] lat);
		sra_pins_t       r;
		logic [EA_W-1:0] m;
		int              top;
		r = '0;
		if (c.newer_variant) begin
			m = bank_mask(c);
			for (int p = EA_LO; p <= EA_HI; p++) begin
				if (p < col_bits(c) + EA_LO)
					r.ea[p-EA_LO] = a[int'(c.bus_width)+p-EA_LO];
				else if (p > NEW_A10_PIN && m[p-EA_LO])
					r.ea[p-EA_LO] = lat[p-EA_LO];
			end
		end else begin
			m   = legacy_mask(c);
			top = c.legacy_width_select ? LEG_CAS_X16 : LEG_CAS_X8;
			for (int p = EA_LO; p <= top; p++)
				r.ea[p-EA_LO] = a[p];
			r.ea = (r.ea & ~m) | (lat & m);
		end
		return r;
	endfunction

	// Bank index, taken from the row-phase pin image of an address
	function automatic logic [BANK_W-1:0] bank_index(input logic [EA_W-1:0] ras,
	                                                 input sra_cfg_t c);
		int b;
		b = bank_pin(c) - EA_LO;
		if (!c.newer_variant)
			return '0;
		return {c.bank_size_field & ras[b+1], ras[b]};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave

	sra_cfg_t         cfg_q;
	logic             wr_pend_q;
	logic [OFF_W-1:0] wr_off_q;
	logic [31:0]      rdata_d;
	logic [31:0]      stat_word;
	sra_cfg_t         cfg_view;
	logic             take;

	assign take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_off_q  <= '0;
		end else if (hready) begin
			wr_pend_q <= take && hwrite;
			wr_off_q  <= haddr[OFF_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_q <= CFG_RST;
		end else if (wr_pend_q && wr_off_q == CFG_OFF) begin
			cfg_q <= sra_cfg_t'(hwdata[CFG_W-1:0]);
		end
	end

	// Forward a write still in its data phase to a read right behind it
	always_comb begin
		cfg_view = cfg_q;
		if (wr_pend_q && wr_off_q == CFG_OFF)
			cfg_view = sra_cfg_t'(hwdata[CFG_W-1:0]);
		rdata_d = '0;
		unique case (haddr[OFF_W-1:0])
			CFG_OFF:  rdata_d = {{(32-CFG_W){1'b0}}, cfg_view};
			STAT_OFF: rdata_d = stat_word;
			default:  rdata_d = '0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= '0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (take && !hwrite)
				hrdata <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Address generation

	logic [EA_W-1:0]   lat_q [NBANK];
	logic [BANK_W-1:0] last_bank_q;
	sra_pins_t         ras_now;
	sra_pins_t         cas_now;
	logic [BANK_W-1:0] bank_now;

	always_comb begin
		ras_now  = ras_map(cmd.addr, cfg_q);
		bank_now = bank_index(ras_now.ea, cfg_q);
		cas_now  = cas_map(cmd.addr, cfg_q, lat_q[bank_now]);
	end

	// Row image captured per bank at activate
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NBANK; i++)
				lat_q[i] <= '0;
			last_bank_q <= '0;
		end else if (cmd.valid && cmd.kind == SRA_CMD_ACTIVATE) begin
			lat_q[bank_now] <= ras_now.ea;
			last_bank_q     <= bank_now;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_addr_pins      <= '0;
			precharge_addr_pin <= 1'b0;
			addr_valid         <= 1'b0;
			addr_kind          <= SRA_CMD_NOP;
		end else begin
			addr_valid <= cmd.valid && cmd.kind != SRA_CMD_NOP;
			if (cmd.valid) begin
				unique case (cmd.kind)
					SRA_CMD_ACTIVATE: begin
						ext_addr_pins      <= ras_now.ea;
						precharge_addr_pin <= ras_now.precharge_addr_pin;
						addr_kind          <= cmd.kind;
					end
					SRA_CMD_READ, SRA_CMD_WRITE: begin
						ext_addr_pins      <= cas_now.ea;
						precharge_addr_pin <= 1'b0;
						addr_kind          <= cmd.kind;
					end
					SRA_CMD_NOP: begin
					end
				endcase
			end
		end
	end

	assign stat_word = {7'h00, addr_kind, last_bank_q, precharge_addr_pin, ext_addr_pins};

endmodule

//--- sra_pkg.sv
// Package for the SDRAM row/column address shifter: constants, types, layouts
package sra_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Widths and pin numbering
	localparam int ADDR_W   = 32;  // Internal byte address width
	localparam int EA_LO    = 2;   // Lowest external address pin number
	localparam int EA_HI    = 21;  // Highest external address pin number
	localparam int EA_W     = EA_HI - EA_LO + 1;
	localparam int NBANK    = 4;   // Latch entries, one per bank index
	localparam int BANK_W   = 2;

	////////////////////////////////////////////////////////////////////////////
	// Legacy variant pin positions
	localparam int LEG_TOP_X16  = 15;  // Highest pin used, width select 1
	localparam int LEG_TOP_X8   = 14;  // Highest pin used, width select 0
	localparam int LEG_GAP_PIN  = 12;  // Absent in legacy; replaced by precharge pin
	localparam int LEG_LOW_TOP  = 11;  // Top of the contiguous low pin group
	localparam int LEG_RAS_X16  = 10;  // Byte bit on pin 2 in a row cycle, x16
	localparam int LEG_RAS_X8   = 11;  // Byte bit on pin 2 in a row cycle, x8
	localparam int LEG_CAS_X16  = 9;   // Highest column pin (pin 9), x16
	localparam int LEG_CAS_X8   = 10;  // Highest column pin (pin 10), x8
	localparam int LEG_LAT_X16_LO = 10;  // Latched pins 15..10, x16
	localparam int LEG_LAT_X8_LO  = 11;  // Latched pins 14..11, x8

	////////////////////////////////////////////////////////////////////////////
	// Newer variant pin positions
	localparam int NEW_COL_BASE = 8;   // Column bits for column size code 00
	localparam int NEW_A10_PIN  = 12;  // Pin wired to SDRAM A10
	localparam int NEW_ROW_TOP  = 16;  // Highest pin driven in a row cycle
	localparam int BANK_PIN_R00 = 13;
	localparam int BANK_PIN_R01 = 14;
	localparam int BANK_PIN_R11 = 15;

	////////////////////////////////////////////////////////////////////////////
	// Register map
	localparam int          OFF_W     = 8;
	localparam logic [7:0]  CFG_OFF   = 8'h00;
	localparam logic [7:0]  STAT_OFF  = 8'h04;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0]  HTRANS_SEQ    = 2'h3;

	typedef enum logic [1:0] {
		SRA_BUS_8  = 2'b00,
		SRA_BUS_16 = 2'b01,
		SRA_BUS_32 = 2'b10
	} sra_bus_t;

	typedef enum logic [1:0] {
		SRA_CMD_NOP      = 2'b00,
		SRA_CMD_ACTIVATE = 2'b01,
		SRA_CMD_READ     = 2'b10,
		SRA_CMD_WRITE    = 2'b11
	} sra_cmd_kind_t;

	// Configuration register layout, bit 0 is the variant select
	typedef struct packed {
		logic [1:0] bus_width;           // 8:7
		logic       bank_size_field;     // 6
		logic [1:0] row_size_field;      // 5:4
		logic [1:0] column_size_field;   // 3:2
		logic       legacy_width_select; // 1
		logic       newer_variant;       // 0
	} sra_cfg_t;

	localparam int       CFG_W   = $bits(sra_cfg_t);
	localparam sra_cfg_t CFG_RST = '0;

	typedef struct packed {
		logic          valid;
		sra_cmd_kind_t kind;
		logic [ADDR_W-1:0] addr;
	} sra_cmd_t;

	typedef struct packed {
		logic            precharge_addr_pin;
		logic [EA_W-1:0] ea;
	} sra_pins_t;

endpackage

//--- sra_shift_properties.sv
// Concurrent checks on the address shifter ports
`timescale 1ns/1ps
module sra_shift_properties
	import sra_pkg::*;
(
	input wire logic            hclk,          // Clock
	input wire logic            hresetn,       // Reset, low
	input wire logic            hsel,          // Select
	input wire logic [1:0]      htrans,        // Transfer
	input wire logic            hwrite,        // Write
	input wire logic            hready,        // Ready in
	input wire logic [31:0]     hrdata,        // Read data
	input wire logic            hreadyout,     // Ready out
	input wire logic            hresp,         // Response
	input wire sra_cmd_t        cmd,           // Command
	input wire logic [EA_W-1:0] ext_addr_pins, // Pins
	input wire logic            precharge_addr_pin, // A10
	input wire logic            addr_valid,    // Pulse
	input wire sra_cmd_kind_t   addr_kind      // Kind
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_take;
		cmd.valid && cmd.kind != SRA_CMD_NOP;
	endsequence
	sequence s_col;
		addr_valid && addr_kind[1];
	endsequence
	AST_PULSE: assert property (s_take |=> addr_valid && addr_kind == $past(cmd.kind))
		else $error("command without pin update");
	AST_QUIET: assert property (!(cmd.valid && cmd.kind != SRA_CMD_NOP) |=> !addr_valid
		&& $stable(ext_addr_pins) && $stable(precharge_addr_pin)) else $error("pins moved idle");
	AST_PRECH: assert property (s_col |-> !precharge_addr_pin)
		else $error("precharge pin high in column cycle");
	AST_EA12: assert property (s_col |-> !ext_addr_pins[NEW_A10_PIN-EA_LO])
		else $error("pin 12 high in column cycle");
	AST_HIGH: assert property (ext_addr_pins[EA_W-1:NEW_ROW_TOP-1] == '0)
		else $error("pins above 16 driven");
	AST_OKAY: assert property (hreadyout && !hresp)
		else $error("bus not ready or error");
	AST_RDHOLD: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
		else $error("read data changed");
	AST_CAUSE: assert property ($rose(addr_valid) |-> $past(cmd.valid))
		else $error("pulse without command");
endmodule
bind sra_shift sra_shift_properties u_props(.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .cmd(cmd), .ext_addr_pins(ext_addr_pins),
	.precharge_addr_pin(precharge_addr_pin), .addr_valid(addr_valid), .addr_kind(addr_kind));

//--- sra_mem_model.sv
// Far-side memory model: records the pin image of each command
`timescale 1ns/1ps
module sra_mem_model
	import sra_pkg::*;
(
	input  wire logic            hclk,               // Clock
	input  wire logic [EA_W-1:0] ext_addr_pins,      // Shared pins
	input  wire logic            precharge_addr_pin, // Legacy A10
	input  wire logic            addr_valid,         // Update pulse
	input  wire sra_cmd_kind_t   addr_kind,          // Command kind
	output logic      [EA_W:0]   row_q,              // Last row image
	output logic      [EA_W:0]   col_q               // Last column image
);
	initial begin
		row_q = '0;
		col_q = '0;
	end
	always @(posedge hclk) begin
		if (addr_valid && addr_kind == SRA_CMD_ACTIVATE) begin
			row_q <= {precharge_addr_pin, ext_addr_pins};
		end
		if (addr_valid && addr_kind[1]) begin
			col_q <= {precharge_addr_pin, ext_addr_pins};
		end
	end
endmodule

//--- sra_shift_tb.sv
// Self-checking bench for the address shifter
`timescale 1ns/1ps
module sra_shift_tb
	import sra_pkg::*;
;
	logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic              addr_valid, precharge_addr_pin;
	logic [31:0]       haddr, hwdata, hrdata, rd;
	logic [1:0]        htrans;
	logic [2:0]        hsize;
	logic [EA_W-1:0]   ext_addr_pins;
	logic [EA_W:0]     row_q, col_q;
	sra_cmd_kind_t     addr_kind;
	sra_cmd_t          cmd;
	sra_cfg_t          cfg;
	int                n_fail, n_compared;
	localparam logic [1:0] RS_TBL [3] = '{2'h0, 2'h1, 2'h3};
	sra_shift DUT(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .cmd(cmd), .ext_addr_pins(ext_addr_pins),
		.precharge_addr_pin(precharge_addr_pin), .addr_valid(addr_valid), .addr_kind(addr_kind));
	sra_mem_model u_mem(.hclk(hclk), .ext_addr_pins(ext_addr_pins), .addr_valid(addr_valid),
		.precharge_addr_pin(precharge_addr_pin), .addr_kind(addr_kind), .row_q(row_q), .col_q(col_q));
	////////////////////////////////////////////////////////////////////////////
	function automatic logic [20:0] pins(sra_cfg_t c, logic col, logic [31:0] a, la);
		logic [19:0] e = '0;
		logic p = 1'b0;
		int cb = 8 + c.column_size_field;
		int s = c.bus_width;
		int bp = (c.row_size_field == 2'h0) ? 13 : (c.row_size_field == 2'h1) ? 14 : 15;
		if (!c.newer_variant && c.legacy_width_select) begin
			e[13:11] = col ? la[23:21] : a[23:21];
			p = col ? 1'b0 : a[20];
			e[9:8] = col ? la[19:18] : a[19:18];
			e[7:0] = col ? a[9:2] : a[17:10];
		end else if (!c.newer_variant) begin
			e[12:11] = col ? la[23:22] : a[23:22];
			p = col ? 1'b0 : a[21];
			e[9] = col ? la[20] : a[20];
			e[8:0] = col ? a[10:2] : a[19:11];
		end else begin
			for (int i = 2; i <= 16; i++) begin
				if (!col) e[i-2] = a[cb+s+i-2];
				else if (i <= cb + 1) e[i-2] = a[s+i-2];
				else if (i >= bp && i <= bp + c.bank_size_field) e[i-2] = la[cb+s+i-2];
			end
		end
		return {p, e};
	endfunction
	task automatic chk(input string nm, input logic [31:0] exp, got);
		n_compared++;
		if (exp !== got) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask
	task automatic ahb(input logic w, input logic [31:0] a, wd);
		int k = 0;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && k++ < 50) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && k++ < 50) @(posedge hclk);
		rd = hrdata;
	endtask
	task automatic send(input sra_cmd_kind_t k, input logic [31:0] a);
		@(posedge hclk);
		cmd <= '{1'b1, k, a};
		@(posedge hclk);
		cmd <= '0;
		#1;
		chk("addr_valid", 32'(k != SRA_CMD_NOP), 32'(addr_valid));
	endtask
	task automatic run_pair(input logic [31:0] a, b);
		send(SRA_CMD_ACTIVATE, a);
		chk("row pins", pins(cfg, 1'b0, a, a), {precharge_addr_pin, ext_addr_pins});
		send(SRA_CMD_READ, b);
		chk("read pins", pins(cfg, 1'b1, b, a), {precharge_addr_pin, ext_addr_pins});
		send(SRA_CMD_NOP, a);
		send(SRA_CMD_WRITE, b);
		chk("write pins", pins(cfg, 1'b1, b, a), {precharge_addr_pin, ext_addr_pins});
		chk("far row", pins(cfg, 1'b0, a, a), row_q);
		chk("far col", pins(cfg, 1'b1, b, a), col_q);
		ahb(1'b0, STAT_OFF, 0);
		chk("status", {2'h3, pins(cfg, 1'b1, b, a)}, {rd[24:23], rd[20:0]});
	endtask
	task automatic conclude();
		if (n_fail == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	initial begin
		#100000;
		n_fail++;
		conclude();
	end
	initial begin
		{hresetn, hsel, haddr, htrans, hwrite, hwdata, cmd, cfg} = '0;
		hsize = 3'h2;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		chk("ready", 32'h2, 32'({hreadyout, hresp}));
		ahb(1'b0, CFG_OFF, 0);
		chk("cfg reset", 0, rd);
		ahb(1'b1, STAT_OFF, 32'hffff_ffff);
		ahb(1'b1, 32'h40, 32'hffff_ffff);
		ahb(1'b0, 32'h40, 0);
		chk("unmapped", 0, rd);
		for (int w = 0; w < 2; w++) begin
			cfg = '0;
			cfg.legacy_width_select = w[0];
			ahb(1'b1, CFG_OFF, 32'(cfg));
			ahb(1'b0, CFG_OFF, 0);
			chk("cfg", 32'(cfg), rd);
			run_pair(32'h0135_9ab4, 32'h01f9_9d48);
		end
		for (int c = 0; c < 3; c++) begin
			for (int s = 0; s < 3; s++) begin
				cfg = '{s[1:0], s[0], RS_TBL[c], c[1:0], 1'b0, 1'b1};
				ahb(1'b1, CFG_OFF, 32'(cfg));
				run_pair(32'h0a5c_3e97, 32'h0a5c_3168);
			end
		end
		conclude();
	end
endmodule
